//--- hdl/dtd_timer.sv
// Dual 8-bit timer, event counter and divider with APB registers
//
// How it works
// - Timer mode counts ticks, matches raise irq, clear
// - Compare writes take effect at once
// - Event mode counts falling pin edges, match clears
// - Divider mode toggles flip-flop on each match
// - Divider pin is inverse of flip-flop
// - Flip-flop loadable by control bit, reset clears
// - Stopped divider keeps its output level
// - Slow operation allows only slowest divided clock
// - Clearing start stops and clears counter
// - Mode 000 timer or event, 001 divider
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module dtd_timer
    import dtd_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock, reset and freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DTD_DATA_W-1:0] pwdata,
    output logic [DTD_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [DTD_NUM_CH-1:0] event_in_pin,
    input wire logic low_freq_clock,
    output logic [DTD_NUM_CH-1:0] divider_out_pin,
    // Interrupt
    output logic irq
);

    // Refuse an address bus too narrow for the map
    if (ADDR_W < 8) begin : g_addr_check
        $error("dtd_timer: ADDR_W must be at least 8");
    end

    // Whole block state
    typedef struct packed {
        dtd_ctrl_s [DTD_NUM_CH-1:0] ctrl;
        logic [DTD_NUM_CH-1:0][DTD_CNT_W-1:0] cmp;
        logic [DTD_NUM_CH-1:0][DTD_CNT_W-1:0] cnt;
        logic [DTD_NUM_CH-1:0] status;
        logic [DTD_NUM_CH-1:0] mask;
        logic slow;
        logic src_sel;
        logic [DTD_DATA_W-1:0] rdata;
        logic err;
    } dtd_state_s;

    dtd_state_s st_reg; // Registered state
    dtd_state_s st_next; // Next state
    dtd_ticks_s ticks; // Internal clock ticks
    logic [DTD_SYNC_W-1:0] pin_fall; // Synchronised falling edges
    logic [DTD_SYNC_W-1:0] pin_rise; // Synchronised rising edges
    logic [DTD_NUM_CH-1:0] tick_c; // Counting step per channel
    logic [DTD_NUM_CH-1:0] hit_c; // Compare match per channel
    logic setup_c; // APB setup phase
    logic wr_c; // APB write completes
    logic [7:0] off_c; // Low address byte

    // Increment an 8-bit count without widening
    function automatic logic [DTD_CNT_W-1:0] inc_cnt(input logic [DTD_CNT_W-1:0] v);
        inc_cnt = v + DTD_CNT_ONE;
    endfunction

    // Map a byte offset to whether it is implemented
    function automatic logic is_mapped(input logic [7:0] off);
        case (off)
            DTD_OFF_CTRL0, DTD_OFF_CMP0, DTD_OFF_CTRL1, DTD_OFF_CMP1,
            DTD_OFF_STATUS, DTD_OFF_MASK, DTD_OFF_COUNT, DTD_OFF_SYSCFG: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = 1'b0;
            end
        endcase
    endfunction

    // Internal clock tick for timer and divider modes
    function automatic logic sel_tick(input dtd_clk_e sel, input dtd_ticks_s t,
                                      input logic slow, input logic src);
        sel_tick = 1'b0;
        if (slow) begin
            // Only the slowest divided clock in slow operation
            sel_tick = (sel == DTD_CLK_SLOWEST) & t.fs8;
        end else begin
            case (sel)
                DTD_CLK_SLOWEST: begin
                    sel_tick = src ? t.fs8 : t.fc2048;
                end
                DTD_CLK_FC128: begin
                    sel_tick = t.fc128;
                end
                DTD_CLK_FC32: begin
                    sel_tick = t.fc32;
                end
                DTD_CLK_FC8: begin
                    sel_tick = t.fc8;
                end
                default: begin
                    sel_tick = 1'b0; // Not a source for these modes
                end
            endcase
        end
    endfunction

    // Event pins and low clock pass the synchroniser
    dtd_edge_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin_in({low_freq_clock, event_in_pin}),
        .fall(pin_fall),
        .rise(pin_rise)
    );

    // Divided clock ticks
    dtd_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .fs_tick(pin_rise[DTD_NUM_CH]),
        .ticks(ticks)
    );

    // Counting step and match per channel
    always_comb begin
        for (int i = 0; i < DTD_NUM_CH; i++) begin
            case (st_reg.ctrl[i].mode)
                DTD_MODE_TIMER: begin
                    // Timer uses internal clock, event uses its pin
                    if (st_reg.ctrl[i].clk_sel == DTD_CLK_NONE) begin
                        tick_c[i] = pin_fall[i];
                    end else begin
                        tick_c[i] = sel_tick(st_reg.ctrl[i].clk_sel, ticks,
                                             st_reg.slow, st_reg.src_sel);
                    end
                end
                DTD_MODE_PDO: begin
                    tick_c[i] = sel_tick(st_reg.ctrl[i].clk_sel, ticks,
                                         st_reg.slow, st_reg.src_sel);
                end
                default: begin
                    tick_c[i] = 1'b0; // Other modes not served here
                end
            endcase
            tick_c[i] = tick_c[i] & st_reg.ctrl[i].run & ce;
            hit_c[i] = tick_c[i] & (inc_cnt(st_reg.cnt[i]) == st_reg.cmp[i]);
        end
    end

    // APB phases
    assign setup_c = psel & ~penable & ce;
    assign wr_c = psel & penable & pwrite & ce;
    assign off_c = paddr[7:0];

    // Next-state logic
    always_comb begin
        st_next = st_reg;
        if (ce) begin
            // Channel counters
            for (int i = 0; i < DTD_NUM_CH; i++) begin
                if (!st_reg.ctrl[i].run) begin
                    st_next.cnt[i] = DTD_CNT_ZERO;
                end else if (hit_c[i]) begin
                    st_next.cnt[i] = DTD_CNT_ZERO;
                    if (st_reg.ctrl[i].mode == DTD_MODE_PDO) begin
                        st_next.ctrl[i].tff = ~st_reg.ctrl[i].tff;
                    end
                end else if (tick_c[i]) begin
                    st_next.cnt[i] = inc_cnt(st_reg.cnt[i]);
                end
            end
            // Register writes
            if (wr_c && paddr[ADDR_W-1:8] == '0) begin
                case (off_c)
                    DTD_OFF_CTRL0: begin
                        st_next.ctrl[0] = dtd_ctrl_s'(pwdata[7:0]);
                        if (!pwdata[3]) begin
                            st_next.cnt[0] = DTD_CNT_ZERO;
                        end
                    end
                    DTD_OFF_CTRL1: begin
                        st_next.ctrl[1] = dtd_ctrl_s'(pwdata[7:0]);
                        if (!pwdata[3]) begin
                            st_next.cnt[1] = DTD_CNT_ZERO;
                        end
                    end
                    DTD_OFF_CMP0: begin
                        st_next.cmp[0] = pwdata[DTD_CNT_W-1:0];
                    end
                    DTD_OFF_CMP1: begin
                        st_next.cmp[1] = pwdata[DTD_CNT_W-1:0];
                    end
                    DTD_OFF_STATUS: begin
                        // Write one to clear
                        st_next.status = st_reg.status & ~pwdata[DTD_NUM_CH-1:0];
                    end
                    DTD_OFF_MASK: begin
                        st_next.mask = pwdata[DTD_NUM_CH-1:0];
                    end
                    DTD_OFF_SYSCFG: begin
                        st_next.slow = pwdata[DTD_SYS_SLOW_BIT];
                        st_next.src_sel = pwdata[DTD_SYS_SRC_BIT];
                    end
                    default: begin
                        st_next.slow = st_reg.slow; // Read-only or unmapped
                    end
                endcase
            end
            // Match sets the sticky bit, winning over a clear
            st_next.status = st_next.status | hit_c;
            // Read data and error captured in the setup phase
            if (setup_c) begin
                st_next.rdata = '0;
                st_next.err = ~is_mapped(off_c) | (paddr[ADDR_W-1:8] != '0);
                case (off_c)
                    DTD_OFF_CTRL0: begin
                        st_next.rdata[7:0] = st_reg.ctrl[0];
                    end
                    DTD_OFF_CTRL1: begin
                        st_next.rdata[7:0] = st_reg.ctrl[1];
                    end
                    DTD_OFF_CMP0: begin
                        st_next.rdata[DTD_CNT_W-1:0] = st_reg.cmp[0];
                    end
                    DTD_OFF_CMP1: begin
                        st_next.rdata[DTD_CNT_W-1:0] = st_reg.cmp[1];
                    end
                    DTD_OFF_STATUS: begin
                        st_next.rdata[DTD_NUM_CH-1:0] = st_reg.status;
                    end
                    DTD_OFF_MASK: begin
                        st_next.rdata[DTD_NUM_CH-1:0] = st_reg.mask;
                    end
                    DTD_OFF_COUNT: begin
                        st_next.rdata[2*DTD_CNT_W-1:0] = st_reg.cnt;
                    end
                    DTD_OFF_SYSCFG: begin
                        st_next.rdata[DTD_SYS_SLOW_BIT] = st_reg.slow;
                        st_next.rdata[DTD_SYS_SRC_BIT] = st_reg.src_sel;
                    end
                    default: begin
                        st_next.rdata = '0; // Unmapped reads as zero
                    end
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.ctrl <= {DTD_NUM_CH{dtd_ctrl_s'(DTD_CTRL_RST)}};
            st_reg.cmp <= {DTD_NUM_CH{DTD_CMP_RST}};
            st_reg.cnt <= {DTD_NUM_CH{DTD_CNT_ZERO}};
            st_reg.status <= '0;
            st_reg.mask <= '0;
            st_reg.slow <= 1'b0;
            st_reg.src_sel <= 1'b0;
            st_reg.rdata <= '0;
            st_reg.err <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    always_comb begin
        for (int i = 0; i < DTD_NUM_CH; i++) begin
            divider_out_pin[i] = ~st_reg.ctrl[i].tff;
        end
    end
    assign irq = |(st_reg.status & st_reg.mask);
    assign prdata = st_reg.rdata;
    assign pready = ce;
    assign pslverr = psel & penable & st_reg.err;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Control write to a channel
    function automatic logic ctrl_wr(input int ch);
        ctrl_wr = wr_c && paddr[ADDR_W-1:8] == '0
                  && off_c == (ch == 0 ? DTD_OFF_CTRL0 : DTD_OFF_CTRL1);
    endfunction

    for (genvar g = 0; g < DTD_NUM_CH; g++) begin : g_chk
        sequence s_match;
            hit_c[g] && !ctrl_wr(g);
        endsequence
        sequence s_cleared;
            st_reg.cnt[g] == DTD_CNT_ZERO && st_reg.status[g];
        endsequence

        a_timer_match_clear: assert property (
            s_match |=> s_cleared)
            else $error("match did not clear counter and set status");

        a_cmp_write_now: assert property (
            wr_c && paddr[ADDR_W-1:8] == '0
            && off_c == (g == 0 ? DTD_OFF_CMP0 : DTD_OFF_CMP1)
            |=> st_reg.cmp[g] == $past(pwdata[DTD_CNT_W-1:0]))
            else $error("compare write not effective next cycle");

        a_event_edge_count: assert property (
            st_reg.ctrl[g].run && st_reg.ctrl[g].mode == DTD_MODE_TIMER
            && st_reg.ctrl[g].clk_sel == DTD_CLK_NONE && ce && pin_fall[g]
            && !hit_c[g] && !ctrl_wr(g)
            |=> st_reg.cnt[g] == inc_cnt($past(st_reg.cnt[g])))
            else $error("event edge not counted");

        a_pdo_toggle_ff: assert property (
            s_match and (st_reg.ctrl[g].mode == DTD_MODE_PDO)
            |=> divider_out_pin[g] != $past(divider_out_pin[g]))
            else $error("divider output did not toggle on match");

        a_pin_follows_ff: assert property (
            $rose(st_reg.ctrl[g].tff) |-> $fell(divider_out_pin[g]))
            else $error("divider pin not inverse of flip-flop");

        a_ff_load_bit: assert property (
            ctrl_wr(g) |=> st_reg.ctrl[g].tff == $past(pwdata[7]))
            else $error("flip-flop not loaded from control bit");

        a_stopped_holds: assert property (
            !st_reg.ctrl[g].run && !ctrl_wr(g)
            |=> $stable(divider_out_pin[g]) && st_reg.cnt[g] == DTD_CNT_ZERO)
            else $error("stopped channel changed its output");

        a_slow_source_only: assert property (
            st_reg.slow && (st_reg.ctrl[g].mode == DTD_MODE_PDO
            || st_reg.ctrl[g].mode == DTD_MODE_TIMER)
            && st_reg.ctrl[g].clk_sel != DTD_CLK_SLOWEST
            && st_reg.ctrl[g].clk_sel != DTD_CLK_NONE |-> !tick_c[g])
            else $error("fast source used in slow operation");

        a_stop_clears_cnt: assert property (
            ctrl_wr(g) && !pwdata[3] |=> st_reg.cnt[g] == DTD_CNT_ZERO [*2])
            else $error("stop did not clear counter");

        a_fall_from_samples: assert property (
            pin_fall[g] |=> !pin_fall[g])
            else $error("falling edge pulse longer than one cycle");
    end

endmodule // dtd_timer

//--- hdl/dtd_pkg.sv
// Shared constants, types and register map of the dual timer divider
package dtd_pkg;

    // Counter and bus widths
    localparam int DTD_CNT_W = 8;
    localparam int DTD_DATA_W = 32;
    localparam int DTD_NUM_CH = 2;
    localparam int DTD_SYNC_W = 3;

    // Register byte offsets
    localparam logic [7:0] DTD_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] DTD_OFF_CMP0 = 8'h04;
    localparam logic [7:0] DTD_OFF_CTRL1 = 8'h08;
    localparam logic [7:0] DTD_OFF_CMP1 = 8'h0c;
    localparam logic [7:0] DTD_OFF_STATUS = 8'h10;
    localparam logic [7:0] DTD_OFF_MASK = 8'h14;
    localparam logic [7:0] DTD_OFF_COUNT = 8'h18;
    localparam logic [7:0] DTD_OFF_SYSCFG = 8'h1c;

    // System configuration field positions
    localparam int DTD_SYS_SLOW_BIT = 0;
    localparam int DTD_SYS_SRC_BIT = 1;

    // Reset values
    localparam logic [7:0] DTD_CTRL_RST = 8'h00;
    localparam logic [7:0] DTD_CMP_RST = 8'hff;
    localparam logic [7:0] DTD_CNT_ZERO = 8'h00;
    localparam logic [7:0] DTD_CNT_ONE = 8'h01;

    // Prescaler taps, as low-order bits that must all be one
    localparam int DTD_TAP_FC8 = 3;
    localparam int DTD_TAP_FC32 = 5;
    localparam int DTD_TAP_FC128 = 7;
    localparam int DTD_TAP_FC2048 = 11;
    localparam logic [2:0] DTD_FS8_LAST = 3'h7;

    // Operating modes of the three-bit mode field
    typedef enum logic [2:0] {
        DTD_MODE_TIMER = 3'h0,
        DTD_MODE_PDO = 3'h1,
        DTD_MODE_PWM = 3'h2,
        DTD_MODE_RSVD = 3'h3,
        DTD_MODE_T16 = 3'h4,
        DTD_MODE_WARM = 3'h5,
        DTD_MODE_PWM16 = 3'h6,
        DTD_MODE_PPG16 = 3'h7
    } dtd_mode_e;

    // Clock select codes
    typedef enum logic [2:0] {
        DTD_CLK_SLOWEST = 3'h0,
        DTD_CLK_FC128 = 3'h1,
        DTD_CLK_FC32 = 3'h2,
        DTD_CLK_FC8 = 3'h3,
        DTD_CLK_FS = 3'h4,
        DTD_CLK_FC2 = 3'h5,
        DTD_CLK_FC = 3'h6,
        DTD_CLK_NONE = 3'h7
    } dtd_clk_e;

    // Channel control register layout; tff is the output flip-flop itself
    typedef struct packed {
        logic tff;
        dtd_clk_e clk_sel;
        logic run;
        dtd_mode_e mode;
    } dtd_ctrl_s;

    // Internal clock ticks, one-cycle enables
    typedef struct packed {
        logic fc;
        logic fc2;
        logic fc8;
        logic fc32;
        logic fc128;
        logic fc2048;
        logic fs;
        logic fs8;
    } dtd_ticks_s;

    // Synchroniser stages
    typedef struct packed {
        logic [DTD_SYNC_W-1:0] s1;
        logic [DTD_SYNC_W-1:0] s2;
        logic [DTD_SYNC_W-1:0] s3;
    } dtd_sync_s;

    // Prescaler state
    typedef struct packed {
        logic [DTD_TAP_FC2048-1:0] div;
        logic [2:0] fs_div;
    } dtd_pre_s;

endpackage

//--- hdl/dtd_edge_sync.sv
// Two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module dtd_edge_sync
    import dtd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Asynchronous pins
    input wire logic [DTD_SYNC_W-1:0] pin_in,
    // Edge pulses
    output logic [DTD_SYNC_W-1:0] fall,
    output logic [DTD_SYNC_W-1:0] rise
);

    dtd_sync_s sync_reg; // All stages
    dtd_sync_s sync_next; // Next stages

    // Shift pins through the stages
    always_comb begin
        sync_next = sync_reg;
        if (ce) begin
            sync_next.s1 = pin_in;
            sync_next.s2 = sync_reg.s1;
            sync_next.s3 = sync_reg.s2;
        end
    end

    // Register stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    // Edges from two successive synchronised samples
    assign fall = ~sync_reg.s2 & sync_reg.s3 & {DTD_SYNC_W{ce}};
    assign rise = sync_reg.s2 & ~sync_reg.s3 & {DTD_SYNC_W{ce}};

endmodule // dtd_edge_sync

//--- hdl/dtd_prescaler.sv
// Free-running divider producing internal clock ticks
`timescale 1ns/1ps
module dtd_prescaler
    import dtd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Low clock rising edge
    input wire logic fs_tick,
    // Tick enables
    output dtd_ticks_s ticks
);

    dtd_pre_s pre_reg; // Divider state
    dtd_pre_s pre_next; // Next divider state

    // Count high clock cycles and low clock edges
    always_comb begin
        pre_next = pre_reg;
        if (ce) begin
            pre_next.div = pre_reg.div + 1'b1;
            if (fs_tick) begin
                pre_next.fs_div = pre_reg.fs_div + 1'b1;
            end
        end
    end

    // Register divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_next;
        end
    end

    // Tick decode, a tick when the low bits roll over
    always_comb begin
        ticks.fc = ce;
        ticks.fc2 = ce & pre_reg.div[0];
        ticks.fc8 = ce & (&pre_reg.div[DTD_TAP_FC8-1:0]);
        ticks.fc32 = ce & (&pre_reg.div[DTD_TAP_FC32-1:0]);
        ticks.fc128 = ce & (&pre_reg.div[DTD_TAP_FC128-1:0]);
        ticks.fc2048 = ce & (&pre_reg.div[DTD_TAP_FC2048-1:0]);
        ticks.fs = fs_tick;
        ticks.fs8 = fs_tick & (pre_reg.fs_div == DTD_FS8_LAST);
    end

endmodule // dtd_prescaler

//--- tb/dtd_event_src.sv
// Partner model: external event pulse source on the event pins
`timescale 1ns/1ps
module dtd_event_src (
    // Clock
    input wire logic pclk,
    // Event pins, idle high
    output logic [1:0] ev
);
    // Idle level before any pulse
    initial ev = 2'b11;

    // One falling pulse, each level held three cycles
    task automatic pulse(input int ch);
        @(posedge pclk);
        ev[ch] <= 1'b0;
        repeat (3) @(posedge pclk);
        ev[ch] <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
endmodule // dtd_event_src

//--- tb/tb.sv
// Self-checking bench for the dual timer divider
`timescale 1ns/1ps
module tb;
    import dtd_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, lfc, err, p;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] ev, pin;
    int err_total, checks, cyc, n;
    // Design under test
    dtd_timer i_dtd_timer (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in_pin(ev),
        .low_freq_clock(lfc), .divider_out_pin(pin), .irq(irq));
    // Event source at the far side
    dtd_event_src i_dtd_event_src (.pclk(pclk), .ev(ev));
    // Clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {4'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Register read and compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Cycles until irq is seen high
    task automatic wait_irq();
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (irq !== 1'b1 && n < 300);
    endtask
    // Cycles until divider pin of channel 0 changes
    task automatic edge_gap();
        logic q;
        q = pin[0];
        n = 0;
        while (pin[0] === q && n < 300) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // Main sequence
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        lfc = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and pin level
        rdc(DTD_OFF_CTRL0, 32'h0);
        rdc(DTD_OFF_CMP0, 32'hff);
        chk({30'h0, pin}, 32'h3);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        // Timer mode, compare 3 on fc/8: 24 cycles a period
        wr(DTD_OFF_MASK, 32'h3);
        wr(DTD_OFF_CMP0, 32'h3);
        wr(DTD_OFF_CTRL0, 32'h38);
        wait_irq();
        rdc(DTD_OFF_STATUS, 32'h1);
        wr(DTD_OFF_STATUS, 32'h1);
        wait_irq();
        chk(n, 18);
        wr(DTD_OFF_MASK, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(DTD_OFF_CTRL0, 32'h30);
        rdc(DTD_OFF_COUNT, 32'h0);
        rdc(DTD_OFF_STATUS, 32'h1);
        wr(DTD_OFF_STATUS, 32'h1);
        rdc(DTD_OFF_STATUS, 32'h0);
        wr(DTD_OFF_MASK, 32'h3);
        $display("test timer done");
        // Event counter on channel 1, compare 3
        wr(DTD_OFF_CMP1, 32'h3);
        wr(DTD_OFF_CTRL1, 32'h78);
        i_dtd_event_src.pulse(1);
        i_dtd_event_src.pulse(1);
        rdc(DTD_OFF_COUNT, 32'h200);
        rdc(DTD_OFF_STATUS, 32'h0);
        i_dtd_event_src.pulse(1);
        rdc(DTD_OFF_STATUS, 32'h2);
        rdc(DTD_OFF_COUNT, 32'h0);
        wr(DTD_OFF_CTRL1, 32'h70);
        wr(DTD_OFF_STATUS, 32'h2);
        $display("test event done");
        // Divider, compare 2 on fc/8: 16 cycles each half
        wr(DTD_OFF_CMP0, 32'h2);
        wr(DTD_OFF_CTRL0, 32'h39);
        edge_gap();
        edge_gap();
        chk(n, 16);
        edge_gap();
        chk(n, 16);
        rdc(DTD_OFF_STATUS, 32'h1);
        apb(1'b0, DTD_OFF_CTRL0, 32'h0);
        chk({31'h0, pin[0]}, {31'h0, ~rd[7]});
        wr(DTD_OFF_CTRL0, rd & 32'hf7);
        p = pin[0];
        repeat (40) @(posedge pclk);
        chk({31'h0, pin[0]}, {31'h0, p});
        wr(DTD_OFF_CTRL0, rd ^ 32'h88);
        @(posedge pclk);
        chk({31'h0, pin[0]}, {31'h0, rd[7]});
        $display("test divider done");
        // Slow operation refuses fc/8, counts only low clock over eight
        wr(DTD_OFF_CMP0, 32'h80);
        wr(DTD_OFF_SYSCFG, 32'h1);
        wr(DTD_OFF_CTRL0, 32'h38);
        repeat (60) @(posedge pclk);
        rdc(DTD_OFF_COUNT, 32'h0);
        wr(DTD_OFF_CTRL0, 32'h30);
        wr(DTD_OFF_CTRL0, 32'h08);
        // Twenty low clock rises give two slowest ticks
        repeat (40) begin
            @(posedge pclk);
            lfc <= ~lfc;
        end
        rdc(DTD_OFF_COUNT, 32'h2);
        $display("test slow done");
        tally_and_finish();
    end
endmodule // tb
